// *** hw/asp_serial_port.sv ***
// Implementation choices: the placing of the registers and the APB slave port.
`include "asp_defs.svh"

module asp_serial_port
  import asp_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  // Interrupt requests per level, source 1 means receive
  output logic irq_high,
  output logic irq_low,
  output logic irq_high_rx,
  output logic irq_low_rx
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic calc_parity(input logic [7:0] data, input logic [2:0] len,
                                       input logic addr_bit, input logic addr_use,
                                       input logic even);
    logic [7:0] mask;
    logic x;
    mask = 8'hff >> (3'h7 - len);
    x = ^(data & mask) ^ (addr_use & addr_bit);
    return even ? x : ~x;
  endfunction

  function automatic logic [12:0] build_frame(input logic [7:0] data, input logic [2:0] len,
                                              input logic addr_use, input logic wake,
                                              input logic par_use, input logic even);
    logic [12:0] f;
    logic [3:0] pos;
    f = 13'h1fff;
    f[0] = 1'b0;
    pos = 4'h1;
    for (int i = 0; i < 8; i++)
    begin
      if (3'(i) <= len)
      begin
        f[pos] = data[i];
        pos = pos + 4'h1;
      end
    end
    if (addr_use)
    begin
      f[pos] = wake;
      pos = pos + 4'h1;
    end
    if (par_use)
    begin
      f[pos] = calc_parity(data, len, wake, addr_use, even);
    end
    return f;
  endfunction

  asp_state_t st;
  asp_state_t next_st;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [2:0] len;
    logic addr_use;
    logic par_use;
    logic [3:0] addr_idx;
    logic [3:0] par_idx;
    logic [3:0] stop_idx;
    logic bitv;
    logic rx_ok;
    logic setup;
    logic access;
    logic hit;
    logic tx_write;
    logic rx_read;
    logic [15:0] per;
    logic rx_req;
    logic tx_req;
    len = st.fmt[`ASP_FMT_LEN_HI:`ASP_FMT_LEN_LO];
    addr_use = st.fmt[`ASP_FMT_ADDR_MODE];
    par_use = st.fmt[`ASP_FMT_PAR_EN];
    addr_idx = {1'b0, len} + 4'h1;
    par_idx = addr_idx + {3'h0, addr_use};
    stop_idx = par_idx + {3'h0, par_use};
    bitv = st.rx_votes[1];
    rx_ok = 1'b0;
    next_st = st;
    setup = psel && !penable;
    access = psel && penable && st.pready;
    hit = (paddr <= `ASP_OFF_TXBUF) && (paddr[1:0] == 2'b00);
    tx_write = access && pwrite && (paddr == `ASP_OFF_TXBUF);
    rx_read = access && !pwrite && (paddr == `ASP_OFF_RXBUF);
    per = (st.baud == 16'h0000) ? 16'h0001 : st.baud;
    rx_req = st.ctl[`ASP_CTL_RX_IE] && (st.rx_full || st.line_break);
    tx_req = st.ctl[`ASP_CTL_TX_IE] && st.tx_room;

    // ----------------------------------------
    // Sample tick
    // ----------------------------------------
    next_st.tick = 1'b0;
    if (st.tick_cnt >= per)
    begin
      next_st.tick_cnt = 16'h0000;
      next_st.tick = 1'b1;
    end
    else
    begin
      next_st.tick_cnt = st.tick_cnt + 16'h0001;
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    next_st.rx_sync1 = serial_in_pin;
    next_st.rx_sync2 = st.rx_sync1;
    if (st.tick)
    begin
      case (st.rx_st)
        ASP_RX_HUNT:
        begin
          if (st.rx_sync2)
          begin
            next_st.rx_phase = 3'h0;
          end
          else if (st.rx_phase == `ASP_START_LOWS)
          begin
            next_st.rx_st = ASP_RX_FRAME;
            next_st.rx_phase = 3'h4;
            next_st.rx_idx = 4'hf;
            next_st.rx_shifter = 8'h00;
            next_st.rx_votes = 2'h0;
          end
          else
          begin
            next_st.rx_phase = st.rx_phase + 3'h1;
          end
        end
        ASP_RX_FRAME:
        begin
          next_st.rx_phase = st.rx_phase + 3'h1;
          if (st.rx_phase >= `ASP_VOTE_FIRST && st.rx_phase <= `ASP_VOTE_LAST && st.rx_sync2)
          begin
            next_st.rx_votes = st.rx_votes + 2'h1;
          end
          if (st.rx_phase == `ASP_PHASE_LAST)
          begin
            next_st.rx_votes = 2'h0;
            next_st.rx_idx = st.rx_idx + 4'h1;
            if (st.rx_idx == 4'hf)
            begin
              next_st.rx_idx = 4'h0;
            end
            else if (st.rx_idx < addr_idx)
            begin
              next_st.rx_shifter[st.rx_idx[2:0]] = bitv;
            end
            else if (addr_use && st.rx_idx == addr_idx)
            begin
              next_st.rx_addr_bit = bitv;
            end
            else if (par_use && st.rx_idx == par_idx)
            begin
              next_st.rx_par_bad = bitv != calc_parity(st.rx_shifter, len, st.rx_addr_bit,
                                                      addr_use, st.fmt[`ASP_FMT_PAR_EVEN]);
            end
            if (st.rx_idx == stop_idx)
            begin
              // Receiver checks one stop bit only
              rx_ok = 1'b1;
              next_st.rx_phase = 3'h0;
              next_st.rx_st = bitv ? ASP_RX_HUNT : ASP_RX_BREAK;
              next_st.rx_brk_cnt = 7'h00;
            end
          end
        end
        ASP_RX_BREAK:
        begin
          if (st.rx_sync2)
          begin
            next_st.rx_st = ASP_RX_HUNT;
          end
          else if (st.rx_brk_cnt == `ASP_BREAK_TICKS - 7'h01)
          begin
            if (!st.ctl[`ASP_CTL_SLEEP])
            begin
              next_st.line_break = 1'b1;
            end
            next_st.rx_brk_cnt = st.rx_brk_cnt + 7'h01;
          end
          else if (st.rx_brk_cnt < `ASP_BREAK_TICKS)
          begin
            next_st.rx_brk_cnt = st.rx_brk_cnt + 7'h01;
          end
        end
        default:
        begin
          next_st.rx_st = ASP_RX_HUNT;
        end
      endcase
    end
    // Asleep, only an address frame may reach software
    if (rx_ok && st.ctl[`ASP_CTL_RX_ON] &&
        (!st.ctl[`ASP_CTL_SLEEP] || (addr_use && next_st.rx_addr_bit)))
    begin
      next_st.rx_holding = next_st.rx_shifter;
      next_st.rx_addr = addr_use && next_st.rx_addr_bit;
      next_st.par_err = par_use && next_st.rx_par_bad;
      next_st.frm_err = !bitv;
      next_st.rx_full = 1'b1;
    end
    else if (rx_read)
    begin
      next_st.rx_full = 1'b0;
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    if (tx_write)
    begin
      next_st.tx_holding = pwdata[7:0];
      next_st.tx_room = 1'b0;
      next_st.tx_idle = 1'b0;
    end
    case (st.tx_st)
      ASP_TX_IDLE:
      begin
        // Off only blocks new loads; a frame in flight always finishes
        if (!st.tx_room && !tx_write && st.ctl[`ASP_CTL_TX_ON])
        begin
          next_st.wake_latch = st.ctl[`ASP_CTL_TX_WAKE];
          next_st.ctl[`ASP_CTL_TX_WAKE] = 1'b0;
          next_st.tx_shifter = build_frame(st.tx_holding, len, addr_use,
                                           st.ctl[`ASP_CTL_TX_WAKE], par_use,
                                           st.fmt[`ASP_FMT_PAR_EVEN]) >> 1;
          next_st.txd = 1'b0;
          next_st.tx_left = stop_idx + 4'h2 + {3'h0, st.fmt[`ASP_FMT_TWO_STOP]};
          next_st.tx_phase = 3'h0;
          next_st.tx_room = 1'b1;
          next_st.tx_idle = 1'b0;
          next_st.tx_st = ASP_TX_SHIFT;
        end
      end
      ASP_TX_SHIFT:
      begin
        if (st.tick)
        begin
          next_st.tx_phase = st.tx_phase + 3'h1;
          if (st.tx_phase == `ASP_PHASE_LAST)
          begin
            next_st.tx_left = st.tx_left - 4'h1;
            if (st.tx_left == 4'h1)
            begin
              next_st.txd = 1'b1;
              next_st.tx_idle = 1'b1;
              next_st.tx_st = ASP_TX_IDLE;
            end
            else
            begin
              next_st.txd = st.tx_shifter[0];
              next_st.tx_shifter = {1'b1, st.tx_shifter[12:1]};
            end
          end
        end
      end
      default:
      begin
        next_st.tx_st = ASP_TX_IDLE;
      end
    endcase

    // ----------------------------------------
    // APB slave, no wait states
    // ----------------------------------------
    next_st.pready = setup;
    next_st.pslverr = setup && !hit;
    if (setup)
    begin
      case (paddr)
        `ASP_OFF_FORMAT: next_st.prdata = {25'h0, st.fmt};
        `ASP_OFF_CONTROL: next_st.prdata = {24'h0, st.ctl};
        `ASP_OFF_BAUD: next_st.prdata = {16'h0, st.baud};
        `ASP_OFF_STATUS: next_st.prdata = {25'h0, st.frm_err, st.par_err, st.rx_addr,
                                           st.line_break, st.rx_full, st.tx_idle, st.tx_room};
        `ASP_OFF_RXBUF: next_st.prdata = {24'h0, st.rx_holding};
        default: next_st.prdata = 32'h0000_0000;
      endcase
    end
    if (access && pwrite)
    begin
      case (paddr)
        `ASP_OFF_FORMAT: next_st.fmt = pwdata[6:0];
        `ASP_OFF_CONTROL: next_st.ctl = pwdata[7:0];
        `ASP_OFF_BAUD: next_st.baud = pwdata[15:0];
        `ASP_OFF_STATUS:
        begin
          // Write one clears break; a new break in the same cycle wins
          if (pwdata[`ASP_ST_BREAK] && !(next_st.line_break && !st.line_break))
          begin
            next_st.line_break = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end

    // ----------------------------------------
    // Interrupt requests
    // ----------------------------------------
    next_st.irq_high = (rx_req && st.ctl[`ASP_CTL_RX_LVL]) ||
                       (tx_req && st.ctl[`ASP_CTL_TX_LVL]);
    next_st.irq_low = (rx_req && !st.ctl[`ASP_CTL_RX_LVL]) ||
                      (tx_req && !st.ctl[`ASP_CTL_TX_LVL]);
    next_st.irq_high_rx = rx_req && st.ctl[`ASP_CTL_RX_LVL];
    next_st.irq_low_rx = rx_req && !st.ctl[`ASP_CTL_RX_LVL];
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.fmt <= `ASP_RST_FORMAT;
      st.ctl <= `ASP_RST_CONTROL;
      st.baud <= `ASP_RST_BAUD;
      st.rx_sync1 <= 1'b1;
      st.rx_sync2 <= 1'b1;
      st.rx_st <= ASP_RX_HUNT;
      st.tx_st <= ASP_TX_IDLE;
      st.tx_shifter <= 13'h1fff;
      st.tx_room <= 1'b1;
      st.tx_idle <= 1'b1;
      st.txd <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign serial_out_pin = st.txd;
  assign irq_high = st.irq_high;
  assign irq_low = st.irq_low;
  assign irq_high_rx = st.irq_high_rx;
  assign irq_low_rx = st.irq_low_rx;

endmodule

// *** include/asp_defs.svh ***
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ASP_OFF_FORMAT 12'h000
`define ASP_OFF_CONTROL 12'h004
`define ASP_OFF_BAUD 12'h008
`define ASP_OFF_STATUS 12'h00c
`define ASP_OFF_RXBUF 12'h010
`define ASP_OFF_TXBUF 12'h014

// ----------------------------------------
// Format register fields
// ----------------------------------------
`define ASP_FMT_LEN_LO 0
`define ASP_FMT_LEN_HI 2
`define ASP_FMT_ADDR_MODE 3
`define ASP_FMT_PAR_EN 4
`define ASP_FMT_PAR_EVEN 5
`define ASP_FMT_TWO_STOP 6

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define ASP_CTL_RX_ON 0
`define ASP_CTL_TX_ON 1
`define ASP_CTL_SLEEP 2
`define ASP_CTL_TX_WAKE 3
`define ASP_CTL_RX_IE 4
`define ASP_CTL_TX_IE 5
`define ASP_CTL_RX_LVL 6
`define ASP_CTL_TX_LVL 7

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define ASP_ST_TX_ROOM 0
`define ASP_ST_TX_IDLE 1
`define ASP_ST_RX_FULL 2
`define ASP_ST_BREAK 3
`define ASP_ST_RX_ADDR 4
`define ASP_ST_PAR_ERR 5
`define ASP_ST_FRM_ERR 6

// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define ASP_RST_FORMAT 7'h00
`define ASP_RST_CONTROL 8'h00
`define ASP_RST_BAUD 16'h0000
`define ASP_TICKS_PER_BIT 8
`define ASP_PHASE_LAST 3'h7
`define ASP_START_LOWS 3'h3
`define ASP_VOTE_FIRST 3'h3
`define ASP_VOTE_LAST 3'h5
`define ASP_BREAK_BITS 10
`define ASP_BREAK_TICKS 7'h50

`endif

// *** include/asp_pkg.sv ***
package asp_pkg;

  typedef enum logic [1:0] {
    ASP_RX_HUNT = 2'b00,
    ASP_RX_FRAME = 2'b01,
    ASP_RX_BREAK = 2'b10
  } asp_rx_state_t;

  typedef enum logic {
    ASP_TX_IDLE = 1'b0,
    ASP_TX_SHIFT = 1'b1
  } asp_tx_state_t;

  typedef struct packed {
    // Configuration
    logic [6:0] fmt;
    logic [7:0] ctl;
    logic [15:0] baud;
    // Tick generator
    logic [15:0] tick_cnt;
    logic tick;
    // Receiver
    logic rx_sync1;
    logic rx_sync2;
    asp_rx_state_t rx_st;
    logic [2:0] rx_phase;
    logic [3:0] rx_idx;
    logic [1:0] rx_votes;
    logic [7:0] rx_shifter;
    logic rx_addr_bit;
    logic rx_par_bad;
    logic [6:0] rx_brk_cnt;
    logic [7:0] rx_holding;
    logic rx_full;
    logic rx_addr;
    logic line_break;
    logic par_err;
    logic frm_err;
    // Transmitter
    asp_tx_state_t tx_st;
    logic [2:0] tx_phase;
    logic [3:0] tx_left;
    logic [12:0] tx_shifter;
    logic [7:0] tx_holding;
    logic wake_latch;
    logic tx_room;
    logic tx_idle;
    logic txd;
    // Bus and requests
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq_high;
    logic irq_low;
    logic irq_high_rx;
    logic irq_low_rx;
  } asp_state_t;

endpackage

// *** testbench/asp_props.sv ***
`include "asp_defs.svh"

module asp_props (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Link and requests
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic irq_high,
  input wire logic irq_low,
  input wire logic irq_high_rx,
  input wire logic irq_low_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Divisor snoop
  // ------
  logic [15:0] baud;
  logic last;
  int run;
  int per;
  logic mapped;
  // Divisor 0 runs like divisor 1
  assign per = (baud == 16'h0000) ? 2 : baud + 1;
  assign mapped = paddr <= `ASP_OFF_TXBUF && paddr[1:0] == 2'b00;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      baud <= 16'h0000;
      last <= 1'b1;
      run <= 0;
    end
    else
    begin
      if (psel && penable && pready && pwrite && paddr == `ASP_OFF_BAUD)
        baud <= pwdata[15:0];
      last <= serial_out_pin;
      run <= (serial_out_pin != last) ? 1 : run + 1;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ------
  // Properties
  // ------
  property p_ready_after_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no pready");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  property p_err_unmapped;
    psel && !penable && !mapped |=> pslverr && pready;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("no pslverr");
  property p_ok_mapped;
    psel && !penable && mapped |=> !pslverr;
  endproperty
  a_ok_mapped: assert property (p_ok_mapped) else $error("stray pslverr");
  property p_err_read_zero;
    pslverr && !pwrite |-> prdata == 32'h0 && pready;
  endproperty
  a_err_read_zero: assert property (p_err_read_zero) else $error("refused read data");
  property p_rx_high;
    irq_high_rx |-> irq_high;
  endproperty
  a_rx_high: assert property (p_rx_high) else $error("rx high alone");
  property p_rx_low;
    irq_low_rx |-> irq_low;
  endproperty
  a_rx_low: assert property (p_rx_low) else $error("rx low alone");
  property p_bit_len;
    $rose(serial_out_pin) |-> run >= 7 * per;
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("low run short");
endmodule

bind asp_serial_port asp_props u_asp_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .irq_high(irq_high),
  .irq_low(irq_low), .irq_high_rx(irq_high_rx), .irq_low_rx(irq_low_rx)
);

// *** testbench/asp_remote_node.sv ***
module asp_remote_node (
  // Clock
  input wire logic clk,
  // Link
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle line rests high
  initial
  begin
    rxd = 1'b1;
  end
  task automatic hold(input logic v, input int c);
    rxd <= v;
    repeat (c) @(posedge clk);
  endtask
  task automatic pulse(input int c);
    hold(1'b0, c);
    hold(1'b1, 1);
  endtask
  // Missing stop holds the line low well past ten bits
  task automatic send(input logic [7:0] d, input int len, input logic am, input logic ab,
    input logic pe, input logic ev, input logic stp, input logic g, input int bc);
    logic p;
    p = ~ev ^ (am & ab);
    hold(1'b0, bc);
    for (int i = 0; i < len; i++)
    begin
      p ^= d[i];
      hold(d[i], (g && i == 1) ? bc / 2 - 1 : bc);
      if (g && i == 1)
      begin
        hold(~d[i], 2);
        hold(d[i], bc / 2 - 1);
      end
    end
    if (am)
      hold(ab, bc);
    if (pe)
      hold(p, bc);
    hold(stp, stp ? bc : 13 * bc);
    rxd <= 1'b1;
  endtask
  task automatic recv(output logic [7:0] d, output logic ab, output logic pb,
    output logic ok, input int len, input logic am, input logic pe, input int bc);
    int n;
    d = 8'h00;
    ab = 1'b0;
    pb = 1'b0;
    n = 0;
    while (txd !== 1'b0 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    repeat (bc / 2) @(posedge clk);
    for (int i = 0; i < len; i++)
    begin
      repeat (bc) @(posedge clk);
      d[i] = txd;
    end
    if (am)
    begin
      repeat (bc) @(posedge clk);
      ab = txd;
    end
    if (pe)
    begin
      repeat (bc) @(posedge clk);
      pb = txd;
    end
    repeat (bc) @(posedge clk);
    ok = txd === 1'b1 && n < 3000;
  endtask
endmodule

// *** testbench/tb_top.sv ***
`include "asp_defs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] FM = `ASP_OFF_FORMAT;
  localparam logic [11:0] CT = `ASP_OFF_CONTROL;
  localparam logic [11:0] BD = `ASP_OFF_BAUD;
  localparam logic [11:0] ST = `ASP_OFF_STATUS;
  localparam logic [11:0] RX = `ASP_OFF_RXBUF;
  localparam logic [11:0] TX = `ASP_OFF_TXBUF;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic sin, sout, irq_high, irq_low, irq_high_rx, irq_low_rx, ab, pb, ok, am, pe, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] d;
  int len = 8;
  int bc = 16;
  int error_cnt = 0;
  int n_checks = 0;
  asp_serial_port u_asp_serial_port (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(sin), .serial_out_pin(sout), .irq_high(irq_high), .irq_low(irq_low),
    .irq_high_rx(irq_high_rx), .irq_low_rx(irq_low_rx)
  );
  asp_remote_node u_asp_remote_node (.clk(pclk), .txd(sout), .rxd(sin));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ------
  // Access tasks
  // ------
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x)
    begin
      error_cnt++;
      $display("FAIL t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // Request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      error_cnt++;
      conclude();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask
  task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r & m, x);
  endtask
  task automatic waitst(input logic [31:0] m, input logic [31:0] x);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, ST, 32'h0);
      n++;
    end
    while ((r & m) !== x && n < 400);
    chk(r & m, x);
    if (n >= 400)
      conclude();
  endtask
  task automatic snd(input logic [7:0] v, input logic a, input logic s, input logic g);
    u_asp_remote_node.send(v, len, am, a, pe, ev, s, g, bc);
  endtask
  task automatic rcv();
    u_asp_remote_node.recv(d, ab, pb, ok, len, am, pe, bc);
  endtask
  // ------
  // Sequence
  // ------
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    am = 1'b1;
    pe = 1'b1;
    ev = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdm(FM, 32'hffffffff, 32'h0);
    rdm(CT, 32'hffffffff, 32'h0);
    rdm(BD, 32'hffffffff, 32'h0);
    rdm(ST, 32'hffffffff, 32'h3);
    apb(1'b0, 12'h018, 32'h0);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    wr(FM, 32'h3f);
    wr(CT, 32'hfb);
    fork
      begin
        rcv();
        chk(32'({d, ab, pb, ok}), 32'({8'ha5, 1'b1, ^{8'ha5, 1'b1}, 1'b1}));
        rcv();
        chk(32'({d, ab, pb, ok}), 32'({8'h3c, 1'b0, ^{8'h3c, 1'b0}, 1'b1}));
      end
      begin
        wr(TX, 32'ha5);
        rdm(CT, 32'h8, 32'h0);
        wr(TX, 32'h3c);
        rdm(ST, 32'h3, 32'h0);
        waitst(32'h1, 32'h1);
        chk(32'({irq_high, irq_high_rx}), 32'h2);
        waitst(32'h2, 32'h2);
      end
    join
    fork
      rcv();
      begin
        wr(TX, 32'h81);
        wr(CT, 32'hf1);
      end
    join
    chk(32'({d, ok}), 32'({8'h81, 1'b1}));
    wr(TX, 32'h42);
    rdm(ST, 32'h3, 32'h0);
    wr(CT, 32'hf3);
    snd(8'h5a, 1'b1, 1'b1, 1'b0);
    waitst(32'h4, 32'h4);
    chk(32'({irq_high, irq_high_rx}), 32'h3);
    rdm(ST, 32'h10, 32'h10);
    rdm(RX, 32'hffffffff, 32'h5a);
    rdm(ST, 32'h4, 32'h0);
    chk(32'(irq_high_rx), 32'h0);
    wr(CT, 32'hf7);
    snd(8'h11, 1'b0, 1'b1, 1'b0);
    repeat (8) @(posedge pclk);
    rdm(ST, 32'h4, 32'h0);
    snd(8'h22, 1'b1, 1'b1, 1'b0);
    waitst(32'h4, 32'h4);
    rdm(RX, 32'hffffffff, 32'h22);
    wr(CT, 32'h02);
    snd(8'h33, 1'b0, 1'b1, 1'b0);
    repeat (8) @(posedge pclk);
    rdm(ST, 32'h4, 32'h0);
    wr(CT, 32'h03);
    snd(8'h44, 1'b0, 1'b1, 1'b0);
    waitst(32'h4, 32'h4);
    chk(32'({irq_high, irq_low}), 32'h0);
    rdm(RX, 32'hffffffff, 32'h44);
    // Short characters, no parity, no address bit
    wr(FM, 32'h04);
    len = 5;
    am = 1'b0;
    pe = 1'b0;
    u_asp_remote_node.pulse(6);
    repeat (8) @(posedge pclk);
    rdm(ST, 32'h4, 32'h0);
    snd(8'h15, 1'b0, 1'b1, 1'b1);
    waitst(32'h4, 32'h4);
    rdm(ST, 32'h40, 32'h0);
    rdm(RX, 32'hffffffff, 32'h15);
    fork
      rcv();
      wr(TX, 32'hf5);
    join
    chk(32'({d, ok}), 32'({8'h15, 1'b1}));
    wr(CT, 32'h13);
    snd(8'h00, 1'b0, 1'b0, 1'b0);
    waitst(32'h8, 32'h8);
    chk(32'({irq_low, irq_low_rx}), 32'h3);
    wr(ST, 32'h8);
    apb(1'b0, RX, 32'h0);
    wr(FM, 32'h07);
    len = 8;
    wr(BD, 32'h3);
    bc = 32;
    snd(8'h96, 1'b0, 1'b1, 1'b0);
    waitst(32'h4, 32'h4);
    rdm(RX, 32'hffffffff, 32'h96);
    fork
      rcv();
      wr(TX, 32'h69);
    join
    chk(32'({d, ok}), 32'({8'h69, 1'b1}));
    wr(BD, 32'h1);
    bc = 16;
    snd(8'h5c, 1'b0, 1'b1, 1'b0);
    waitst(32'h4, 32'h4);
    rdm(RX, 32'hffffffff, 32'h5c);
    // Odd parity and two stop bits; a wrong parity must be flagged
    wr(FM, 32'h57);
    pe = 1'b1;
    ev = 1'b0;
    snd(8'hc3, 1'b0, 1'b1, 1'b0);
    waitst(32'h4, 32'h4);
    rdm(ST, 32'h60, 32'h0);
    rdm(RX, 32'hffffffff, 32'hc3);
    ev = 1'b1;
    snd(8'hc3, 1'b0, 1'b1, 1'b0);
    waitst(32'h4, 32'h4);
    rdm(ST, 32'h20, 32'h20);
    fork
      rcv();
      wr(TX, 32'h3a);
    join
    chk(32'({d, pb, ok}), 32'({8'h3a, 1'b1, 1'b1}));
    // Early in the second stop bit the frame is still running
    repeat (8) @(posedge pclk);
    rdm(ST, 32'h2, 32'h0);
    waitst(32'h2, 32'h2);
    conclude();
  end
endmodule
